// >>> common/tcc_pkg.sv
package tcc_pkg;

  // Register byte addresses
  localparam logic [31:0] TCC_CTRL_OFS = 32'hfff7c000;
  localparam logic [31:0] TCC_MODE_OFS = 32'hfff7c004;
  localparam logic [31:0] TCC_COUNT_OFS = 32'hfff7c010;
  localparam logic [31:0] TCC_FIRST_OFS = 32'hfff7c014;
  localparam logic [31:0] TCC_SECOND_OFS = 32'hfff7c018;
  localparam logic [31:0] TCC_THIRD_OFS = 32'hfff7c01c;
  localparam logic [31:0] TCC_SR_OFS = 32'hfff7c020;
  localparam logic [31:0] TCC_IER_OFS = 32'hfff7c024;
  localparam logic [31:0] TCC_IDR_OFS = 32'hfff7c028;
  localparam logic [31:0] TCC_IMR_OFS = 32'hfff7c02c;

  // Control command bits
  localparam int TCC_CLKEN_BIT = 0;
  localparam int TCC_CLKDIS_BIT = 1;
  localparam int TCC_SWTRG_BIT = 2;

  // Mode register fields
  localparam int TCC_WAVE_BIT = 15;
  localparam int TCC_LOAD_FIRST_LSB = 16;
  localparam int TCC_LOAD_SECOND_LSB = 18;
  localparam int TCC_ACT_A_LSB = 16;
  localparam int TCC_ACT_B_LSB = 24;

  // Status bits
  localparam int TCC_FLAG_W = 8;
  localparam int TCC_OVF_BIT = 0;
  localparam int TCC_OVR_BIT = 1;
  localparam int TCC_MATCH_A_BIT = 2;
  localparam int TCC_MATCH_B_BIT = 3;
  localparam int TCC_MATCH_C_BIT = 4;
  localparam int TCC_LOAD_A_BIT = 5;
  localparam int TCC_LOAD_B_BIT = 6;
  localparam int TCC_ETRG_BIT = 7;
  localparam int TCC_CLKON_BIT = 16;
  localparam int TCC_MIRROR_A_BIT = 17;
  localparam int TCC_MIRROR_B_BIT = 18;

  // Flags that exist only in one mode
  localparam logic [7:0] TCC_WAVE_ONLY = 8'h0c;
  localparam logic [7:0] TCC_CAPT_ONLY = 8'h62;

  // Reset values
  localparam logic [31:0] TCC_MODE_RST = 32'h00000000;
  localparam logic [15:0] TCC_CNT_RST = 16'h0000;
  localparam logic [7:0] TCC_FLAGS_RST = 8'h00;
  localparam logic [7:0] TCC_MASK_RST = 8'h00;

  // Line event slots, lowest priority first
  localparam int TCC_EVT_N = 4;
  localparam int TCC_EVT_OWN = 0;
  localparam int TCC_EVT_THIRD = 1;
  localparam int TCC_EVT_EXT = 2;
  localparam int TCC_EVT_SW = 3;

  typedef enum logic [1:0] {
    TCC_ACT_NONE,
    TCC_ACT_SET,
    TCC_ACT_CLEAR,
    TCC_ACT_TOGGLE
  } tcc_act_t;

endpackage : tcc_pkg

// >>> common/tcc_act_if.sv
`timescale 1ns/1ps
interface tcc_act_if;
  logic [3:0] evt;
  logic [7:0] code;
  logic enable;
  logic level;

  modport drive (output evt, output code, output enable, input level);
  modport apply (input evt, input code, input enable, output level);
endinterface : tcc_act_if

// >>> logic/tcc_line_action.sv
`timescale 1ns/1ps
module tcc_line_action
  import tcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  tcc_act_if.apply act
);

  logic level_reg;
  logic level_next;
  logic hit;
  tcc_act_t pick;

  // Highest active slot wins
  always_comb begin
    hit = 1'b0;
    pick = TCC_ACT_NONE;
    for (int i = 0; i < TCC_EVT_N; i++) begin
      if (act.evt[i]) begin
        hit = 1'b1;
        pick = tcc_act_t'(act.code[2*i +: 2]);
      end
    end
  end

  always_comb begin
    level_next = level_reg;
    if (act.enable && hit) begin
      case (pick)
        TCC_ACT_SET: level_next = 1'b1;
        TCC_ACT_CLEAR: level_next = 1'b0;
        TCC_ACT_TOGGLE: level_next = ~level_reg;
        default: level_next = level_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  assign act.level = level_reg;

endmodule : tcc_line_action

// >>> logic/tcc_channel.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - First register match in waveform mode applies its action to line A.
// - Third register match in waveform mode applies its own action to line A.
// - Selected external event in waveform mode applies its own action to line A.
// - Software trigger in waveform mode applies its own action to line A.
// - Second register match in waveform mode applies its action to line B.
// - Third register match in waveform mode applies its own action to line B.
// - Selected external event in waveform mode applies its own action to line B.
// - Software trigger in waveform mode applies its own action to line B.
// - Count register reads live 16-bit count, upper bits zero, not writable.
// - First register: read-only in capture mode, writable in waveform mode.
// - Second register: read-only in capture mode, writable in waveform mode.
// - Third register is read-write in both modes.
// - Overflow sets bit 0; event flags clear when status is read.
// - Overrun flag on unread double load in capture; zero in waveform.
// - First and second match flags in waveform only; zero in capture.
// - Third match flag set in both modes.
// - Load flags in capture only; zero in waveform.
// - External trigger flag set on each external trigger.
// - Status bit 16 shows counter clock enabled; not cleared by reads.
// - Status bits 17, 18 mirror line levels, pin or driven.
// - Writing one to enable register enables source; zero does nothing.
// - Disable register clears sources; mask register reads enabled state.
// - Mode bit set selects waveform, clear selects capture.
module tcc_channel
  import tcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdata,
  input wire logic countTick,
  input wire logic extEvent,
  input wire logic extTrigger,
  input wire logic channelLineOneIn,
  output logic channelLineOneOut,
  output logic channelLineOneOe,
  input wire logic channelLineTwoIn,
  output logic channelLineTwoOut,
  output logic channelLineTwoOe,
  output logic chanIrq
);

  logic [31:0] mode_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic clkOn_reg;
  logic [CNT_W-1:0] firstVal_reg;
  logic [CNT_W-1:0] secondVal_reg;
  logic [CNT_W-1:0] thirdVal_reg;
  logic unreadFirst_reg;
  logic unreadSecond_reg;
  logic [TCC_FLAG_W-1:0] flags_reg;
  logic [TCC_FLAG_W-1:0] flags_next;
  logic [TCC_FLAG_W-1:0] flagSet;
  logic [TCC_FLAG_W-1:0] flagView;
  logic [TCC_FLAG_W-1:0] mask_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic linePrev_reg;
  logic irq_reg;

  logic wave;
  logic ctrlWr;
  logic swTrig;
  logic restart;
  logic countStep;
  logic overflow;
  logic matchFirst;
  logic matchSecond;
  logic matchThird;
  logic lineRise;
  logic lineFall;
  logic loadFirst;
  logic loadSecond;
  logic overrun;
  logic rdFirst;
  logic rdSecond;
  logic rdStatus;
  logic mirrorA;
  logic mirrorB;

  tcc_act_if actA ();
  tcc_act_if actB ();

  function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
    edgeHit = (sel[0] && rise) || (sel[1] && fall);
  endfunction : edgeHit

  assign wave = mode_reg[TCC_WAVE_BIT];
  assign ctrlWr = regWrStb && (regAddr == TCC_CTRL_OFS);
  assign swTrig = ctrlWr && regWdata[TCC_SWTRG_BIT];
  assign restart = swTrig || extTrigger;
  assign countStep = clkOn_reg && countTick;
  assign overflow = countStep && (count_reg == {CNT_W{1'b1}});
  assign matchFirst = countStep && (count_reg == firstVal_reg);
  assign matchSecond = countStep && (count_reg == secondVal_reg);
  assign matchThird = countStep && (count_reg == thirdVal_reg);
  assign lineRise = channelLineOneIn && !linePrev_reg;
  assign lineFall = !channelLineOneIn && linePrev_reg;
  assign loadFirst = !wave && edgeHit(mode_reg[TCC_LOAD_FIRST_LSB +: 2], lineRise, lineFall);
  assign loadSecond = !wave && edgeHit(mode_reg[TCC_LOAD_SECOND_LSB +: 2], lineRise, lineFall);
  assign rdFirst = regRdStb && (regAddr == TCC_FIRST_OFS);
  assign rdSecond = regRdStb && (regAddr == TCC_SECOND_OFS);
  assign rdStatus = regRdStb && (regAddr == TCC_SR_OFS);
  assign overrun = (loadFirst && unreadFirst_reg && !rdFirst) ||
                   (loadSecond && unreadSecond_reg && !rdSecond);

  // Mode register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= TCC_MODE_RST;
    end else if (regWrStb && (regAddr == TCC_MODE_OFS)) begin
      mode_reg <= regWdata;
    end
  end

  // Counter and its clock gate
  always_comb begin
    count_next = count_reg;
    if (restart) begin
      count_next = TCC_CNT_RST;
    end else if (countStep) begin
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= TCC_CNT_RST;
      clkOn_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (ctrlWr && regWdata[TCC_CLKDIS_BIT]) begin
        clkOn_reg <= 1'b0;
      end else if ((ctrlWr && regWdata[TCC_CLKEN_BIT]) || restart) begin
        clkOn_reg <= 1'b1;
      end
    end
  end

  // Capture and compare values
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      firstVal_reg <= TCC_CNT_RST;
      secondVal_reg <= TCC_CNT_RST;
      thirdVal_reg <= TCC_CNT_RST;
    end else begin
      if (loadFirst) begin
        firstVal_reg <= count_reg;
      end else if (wave && regWrStb && (regAddr == TCC_FIRST_OFS)) begin
        firstVal_reg <= regWdata[CNT_W-1:0];
      end
      if (loadSecond) begin
        secondVal_reg <= count_reg;
      end else if (wave && regWrStb && (regAddr == TCC_SECOND_OFS)) begin
        secondVal_reg <= regWdata[CNT_W-1:0];
      end
      if (regWrStb && (regAddr == TCC_THIRD_OFS)) begin
        thirdVal_reg <= regWdata[CNT_W-1:0];
      end
    end
  end

  // Unread tracking for overrun; a load wins over a read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unreadFirst_reg <= 1'b0;
      unreadSecond_reg <= 1'b0;
      linePrev_reg <= 1'b0;
    end else begin
      linePrev_reg <= channelLineOneIn;
      unreadFirst_reg <= loadFirst || (unreadFirst_reg && !rdFirst);
      unreadSecond_reg <= loadSecond || (unreadSecond_reg && !rdSecond);
    end
  end

  // Event flags
  always_comb begin
    flagSet = '0;
    flagSet[TCC_OVF_BIT] = overflow;
    flagSet[TCC_OVR_BIT] = !wave && overrun;
    flagSet[TCC_MATCH_A_BIT] = wave && matchFirst;
    flagSet[TCC_MATCH_B_BIT] = wave && matchSecond;
    flagSet[TCC_MATCH_C_BIT] = matchThird;
    flagSet[TCC_LOAD_A_BIT] = loadFirst;
    flagSet[TCC_LOAD_B_BIT] = loadSecond;
    flagSet[TCC_ETRG_BIT] = extTrigger;
  end

  assign flags_next = (rdStatus ? TCC_FLAGS_RST : flags_reg) | flagSet;
  assign flagView = flags_reg & ~(wave ? TCC_CAPT_ONLY : TCC_WAVE_ONLY);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flags_reg <= TCC_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Interrupt source mask
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_reg <= TCC_MASK_RST;
    end else if (regWrStb && (regAddr == TCC_IER_OFS)) begin
      mask_reg <= mask_reg | regWdata[TCC_FLAG_W-1:0];
    end else if (regWrStb && (regAddr == TCC_IDR_OFS)) begin
      mask_reg <= mask_reg & ~regWdata[TCC_FLAG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flagView & mask_reg);
    end
  end

  // Line actions
  assign actA.enable = wave;
  assign actA.code = mode_reg[TCC_ACT_A_LSB +: 8];
  assign actA.evt = {swTrig, extEvent, matchThird, matchFirst};
  assign actB.enable = wave;
  assign actB.code = mode_reg[TCC_ACT_B_LSB +: 8];
  assign actB.evt = {swTrig, extEvent, matchThird, matchSecond};

  tcc_line_action lineOneAct (
    .clk(clk),
    .rst_b(rst_b),
    .act(actA.apply)
  );

  tcc_line_action lineTwoAct (
    .clk(clk),
    .rst_b(rst_b),
    .act(actB.apply)
  );

  assign mirrorA = wave ? actA.level : channelLineOneIn;
  assign mirrorB = wave ? actB.level : channelLineTwoIn;

  // Read data, valid the cycle after the strobe
  always_comb begin
    rdata_next = 32'h00000000;
    case (regAddr)
      TCC_MODE_OFS: rdata_next = mode_reg;
      TCC_COUNT_OFS: rdata_next[CNT_W-1:0] = count_reg;
      TCC_FIRST_OFS: rdata_next[CNT_W-1:0] = firstVal_reg;
      TCC_SECOND_OFS: rdata_next[CNT_W-1:0] = secondVal_reg;
      TCC_THIRD_OFS: rdata_next[CNT_W-1:0] = thirdVal_reg;
      TCC_SR_OFS: begin
        rdata_next[TCC_FLAG_W-1:0] = flagView;
        rdata_next[TCC_CLKON_BIT] = clkOn_reg;
        rdata_next[TCC_MIRROR_A_BIT] = mirrorA;
        rdata_next[TCC_MIRROR_B_BIT] = mirrorB;
      end
      TCC_IMR_OFS: rdata_next[TCC_FLAG_W-1:0] = mask_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_reg <= 32'h00000000;
    end else if (regRdStb) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // Pin drive
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channelLineOneOe <= 1'b0;
      channelLineTwoOe <= 1'b0;
    end else begin
      channelLineOneOe <= wave;
      channelLineTwoOe <= wave;
    end
  end

  assign channelLineOneOut = actA.level;
  assign channelLineTwoOut = actB.level;
  assign regRdata = rdata_reg;
  assign chanIrq = irq_reg;

  // Checks
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!rst_b)
    overflow |=> flags_reg[TCC_OVF_BIT])
    else $error("overflow flag not set");

  AST_SR_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    rdStatus && (flagSet == '0) |=> (flags_reg == '0))
    else $error("status read did not clear flags");

  AST_COUNT_READ: assert property (@(posedge clk) disable iff (!rst_b)
    regRdStb && (regAddr == TCC_COUNT_OFS) |=> (regRdata == {16'h0000, $past(count_reg)}))
    else $error("count read wrong");

  AST_FIRST_RO: assert property (@(posedge clk) disable iff (!rst_b)
    !wave && !loadFirst && regWrStb && (regAddr == TCC_FIRST_OFS) |=> $stable(firstVal_reg))
    else $error("first register written in capture mode");

  AST_SECOND_WR: assert property (@(posedge clk) disable iff (!rst_b)
    wave && regWrStb && (regAddr == TCC_SECOND_OFS) |=> (secondVal_reg == $past(regWdata[15:0])))
    else $error("second register write lost");

  AST_THIRD_WR: assert property (@(posedge clk) disable iff (!rst_b)
    regWrStb && (regAddr == TCC_THIRD_OFS) ##1 !regWrStb ##1 regRdStb && (regAddr == TCC_THIRD_OFS)
      |=> (regRdata[15:0] == $past(regWdata[15:0], 3)))
    else $error("third register readback wrong");

  AST_CAPT_MATCH_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    rdStatus && !wave |=> (regRdata[TCC_MATCH_B_BIT:TCC_MATCH_A_BIT] == 2'h0))
    else $error("match flags visible in capture mode");

  AST_IER_SET: assert property (@(posedge clk) disable iff (!rst_b)
    regWrStb && (regAddr == TCC_IER_OFS) |=> ((mask_reg & $past(regWdata[7:0])) == $past(regWdata[7:0]))
      && ((mask_reg & ~$past(regWdata[7:0])) == ($past(mask_reg) & ~$past(regWdata[7:0]))))
    else $error("enable write wrong");

  AST_IDR_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    regWrStb && (regAddr == TCC_IDR_OFS) |=> ((mask_reg & $past(regWdata[7:0])) == 8'h00))
    else $error("disable write wrong");

  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
    (|(flags_reg & mask_reg & ~(TCC_WAVE_ONLY | TCC_CAPT_ONLY))) |=> chanIrq)
    else $error("interrupt output missing");

  AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    ((flags_reg & mask_reg) == 8'h00) |=> !chanIrq)
    else $error("interrupt output without enabled flag");

  AST_SW_SET_A: assert property (@(posedge clk) disable iff (!rst_b)
    wave && swTrig && (mode_reg[23:22] == 2'h1) |=> channelLineOneOut)
    else $error("software trigger did not set line A");

  AST_CLKON_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    rdStatus && !ctrlWr && !restart |=> (regRdata[TCC_CLKON_BIT] == clkOn_reg))
    else $error("clock status disturbed by read");

endmodule : tcc_channel

// >>> test/tcc_line_model.sv
`timescale 1ns/1ps
// Far-side drivers of the two channel lines
module tcc_line_model (
  input wire logic levelOne,
  input wire logic levelTwo,
  input wire logic outOne,
  input wire logic oeOne,
  input wire logic outTwo,
  input wire logic oeTwo,
  output logic inOne,
  output logic inTwo
);
  // Wire level, channel wins while it drives
  assign inOne = oeOne ? outOne : levelOne;
  assign inTwo = oeTwo ? outTwo : levelTwo;
endmodule : tcc_line_model

// >>> test/tb_tcc_channel.sv
`timescale 1ns/1ps
module tb_tcc_channel
  import tcc_pkg::*;
;
  logic clk, rst_b, regWrStb, regRdStb, countTick, extEvent, extTrigger, chanIrq;
  logic [31:0] regAddr, regWdata, regRdata;
  logic oneIn, oneOut, oneOe, twoIn, twoOut, twoOe, lvlOne, lvlTwo;
  logic [1:0] expLines;
  logic [1:0] code;
  logic [15:0] cnt;
  int errTotal, compares;

  tcc_channel #(.CNT_W(16)) uut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdata(regRdata), .countTick(countTick),
    .extEvent(extEvent), .extTrigger(extTrigger), .channelLineOneIn(oneIn), .channelLineOneOut(oneOut),
    .channelLineOneOe(oneOe), .channelLineTwoIn(twoIn), .channelLineTwoOut(twoOut),
    .channelLineTwoOe(twoOe), .chanIrq(chanIrq));

  tcc_line_model partner (.levelOne(lvlOne), .levelTwo(lvlTwo), .outOne(oneOut), .oeOne(oneOe),
    .outTwo(twoOut), .oeTwo(twoOe), .inOne(oneIn), .inTwo(twoIn));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rd

  task automatic ticks(input int n);
    @(posedge clk);
    countTick <= 1'b1;
    repeat (n) @(posedge clk);
    countTick <= 1'b0;
    cnt = cnt + 16'(n);
  endtask : ticks

  task automatic evt(input bit trig);
    @(posedge clk);
    if (trig) begin
      extTrigger <= 1'b1;
    end else begin
      extEvent <= 1'b1;
    end
    @(posedge clk);
    extTrigger <= 1'b0;
    extEvent <= 1'b0;
  endtask : evt

  // Move compare values out of reach of the count
  task automatic park();
    wr(TCC_FIRST_OFS, 32'h00008000);
    wr(TCC_SECOND_OFS, 32'h00008000);
    wr(TCC_THIRD_OFS, 32'h00008000);
  endtask : park

  task automatic fire(input int line, input int src);
    case (src)
      TCC_EVT_OWN: begin
        wr((line != 0) ? TCC_SECOND_OFS : TCC_FIRST_OFS, {16'h0000, cnt});
        ticks(1);
      end
      TCC_EVT_THIRD: begin
        wr(TCC_THIRD_OFS, {16'h0000, cnt});
        ticks(1);
      end
      TCC_EVT_EXT: evt(1'b0);
      default: begin
        wr(TCC_CTRL_OFS, 32'h1 << TCC_SWTRG_BIT);
        cnt = 16'h0000;
        park();
      end
    endcase
  endtask : fire

  task automatic printVerdict();
    $display("Counts: %0d compares, %0d mismatches", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : printVerdict

  initial begin
    repeat (90000) @(posedge clk);
    errTotal++;
    printVerdict();
  end

  initial begin
    rst_b = 1'b0;
    regAddr = 32'h00000000;
    regWdata = 32'h00000000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    countTick = 1'b0;
    extEvent = 1'b0;
    extTrigger = 1'b0;
    lvlOne = 1'b0;
    lvlTwo = 1'b1;
    expLines = 2'h0;
    code = 2'h0;
    cnt = 16'h0000;
    errTotal = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Capture mode
    rd(TCC_COUNT_OFS, 32'h00000000);
    wr(TCC_COUNT_OFS, 32'h00001234);
    rd(TCC_COUNT_OFS, 32'h00000000);
    rd(32'hfff7c030, 32'h00000000);
    rd(TCC_SR_OFS, 32'h00040000);
    wr(TCC_MODE_OFS, 32'h00090000);
    wr(TCC_THIRD_OFS, 32'h000000a5);
    rd(TCC_THIRD_OFS, 32'h000000a5);
    wr(TCC_FIRST_OFS, 32'h00005555);
    wr(TCC_SECOND_OFS, 32'h00006666);
    rd(TCC_FIRST_OFS, 32'h00000000);
    rd(TCC_SECOND_OFS, 32'h00000000);
    chk(32'({twoOe, oneOe}), 32'h00000000);
    wr(TCC_CTRL_OFS, 32'h1 << TCC_CLKEN_BIT);
    ticks(5);
    rd(TCC_COUNT_OFS, 32'h00000005);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      lvlOne <= ~lvlOne;
      repeat (3) @(posedge clk);
    end
    rd(TCC_SR_OFS, 32'h00070062);
    rd(TCC_SR_OFS, 32'h00070000);
    rd(TCC_FIRST_OFS, 32'h00000005);
    rd(TCC_SECOND_OFS, 32'h00000005);
    ticks(65536);
    rd(TCC_SR_OFS, 32'h00070011);
    wr(TCC_IER_OFS, 32'h00000081);
    wr(TCC_IER_OFS, 32'h00000000);
    rd(TCC_IMR_OFS, 32'h00000081);
    wr(TCC_IDR_OFS, 32'h00000001);
    rd(TCC_IMR_OFS, 32'h00000080);
    chk(32'(chanIrq), 32'h00000000);
    evt(1'b1);
    repeat (3) @(posedge clk);
    #1 chk(32'(chanIrq), 32'h00000001);
    rd(TCC_SR_OFS, 32'h00070080);
    repeat (2) @(posedge clk);
    #1 chk(32'(chanIrq), 32'h00000000);
    rd(TCC_COUNT_OFS, 32'h00000000);
    // Enable and disable together, disable wins
    wr(TCC_CTRL_OFS, 32'h00000003);
    rd(TCC_SR_OFS, 32'h00060000);
    ticks(3);
    rd(TCC_COUNT_OFS, 32'h00000000);
    // Both loads on each edge
    wr(TCC_MODE_OFS, 32'h000f0000);
    @(posedge clk);
    lvlOne <= 1'b0;
    repeat (3) @(posedge clk);
    rd(TCC_SR_OFS, 32'h00040060);
    rd(TCC_FIRST_OFS, 32'h00000000);
    rd(TCC_SECOND_OFS, 32'h00000000);
    wr(TCC_CTRL_OFS, 32'h1 << TCC_CLKEN_BIT);
    cnt = 16'h0000;
    $display("test capture done");
    // Waveform mode, every code from every source on both lines
    wr(TCC_MODE_OFS, 32'h1 << TCC_WAVE_BIT);
    park();
    rd(TCC_SR_OFS, 32'h00010000);
    chk(32'({twoOe, oneOe}), 32'h00000003);
    for (int l = 0; l < 2; l++) begin
      for (int s = 0; s < TCC_EVT_N; s++) begin
        for (int k = 0; k < 4; k++) begin
          code = 2'(k + 1);
          wr(TCC_MODE_OFS, (32'h1 << TCC_WAVE_BIT) | (32'(code) << ((l != 0 ? TCC_ACT_B_LSB : TCC_ACT_A_LSB) + 2 * s)));
          fire(l, s);
          expLines[l] = code == 2'h1 ? 1'b1 : code == 2'h2 ? 1'b0 : code == 2'h3 ? ~expLines[l] : expLines[l];
          repeat (2) @(posedge clk);
          #1 chk(32'({twoOut, oneOut}), 32'(expLines));
        end
      end
    end
    rd(TCC_SR_OFS, 32'h0007001c);
    rd(TCC_FIRST_OFS, 32'h00008000);
    rd(TCC_SECOND_OFS, 32'h00008000);
    $display("test waveform done");
    printVerdict();
  end
endmodule : tb_tcc_channel
